/* File: design/pss_ctl.sv */
`timescale 1ns/100ps
// Functional notes
// [R1] Reference ratio is 14-bit, 5 to 16383
// [R2] Main ratio is 11-bit, 5 to 2047
// [R3] Host never loads a ratio below five
// [R4] Swallow count is 7-bit, 0 to 127
// [R5] Fields are plain unsigned binary, LSB first; the code takes them MSB first
// [R6] Prescaler select: high 64-based, low 128/129
// [R7] Monitor select: high monitor, low lock
// [R8] Polarity bit inverts pump and comparator outputs
// [R9] Polarity high output table
// [R10] Polarity low output table
// [R11] Monitor shows reference or feedback by polarity
// [R12] Power save low stops nonessential logic
// [R13] Tristate input low floats the pump
// [R14] Power save floats pump, shows locked
// [R15] Wake-up limits phase error drive width
// [R16] Serial path works during power save
// [R17] Host holds power save low at power-on
// [R18] Host keeps tristate high in power save
// [R19] One bit shifted per serial rising edge
// [R20] Target bit picks reference or divider latch
// [R21] Strobe high copies shift word to latch
// [R22] Bit order fixed, target select last
// [R23] Latches hold through power save
module pss_ctl (
  input  wire logic        sys_clk,            // System clock
  input  wire logic        resetn,             // Async reset, low
  input  wire logic        psel,               // APB select
  input  wire logic        penable,            // APB enable
  input  wire logic        pwrite,             // APB direction
  input  wire logic [7:0]  paddr,              // APB byte address
  input  wire logic [31:0] pwdata,             // APB write data
  output logic      [31:0] prdata,             // APB read data
  output logic             pready,             // APB ready
  output logic             pslverr,            // APB error
  input  wire logic        serDataIn,          // Serial data pin
  input  wire logic        serClkIn,           // Serial clock pin
  input  wire logic        latchStrobeIn,      // Latch strobe pin
  input  wire logic        powerSaveNIn,       // Power save pin, low saves
  input  wire logic        pumpTristateNIn,    // Pump tristate pin, low floats
  input  wire logic        oscTickIn,          // Reference oscillator pin
  input  wire logic        prescTickIn,        // Prescaler output pin
  output logic             prescRatioSel,      // High 64-based, low 128/129
  output logic             prescModulusHigh,   // Swallow phase, divide by M+1
  output logic             pumpOut,            // Pump drive level
  output logic             pumpOeN,            // Pump enable, low drives
  output logic             phaseRefOut,        // Reference-side comparator out
  output logic             phaseFbOut,         // Feedback-side open drain level
  output logic             phaseFbOeN,         // Feedback-side enable, low drives
  output logic             lockMonitorOut,     // Shared lock/monitor output
  output logic             powerSaveActive     // Power save in force
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [pss_pkg::SY_W-1:0] syncA_reg, syncA_next, syncB_reg, syncB_next;
  logic [2:0]               prev_reg, prev_next;
  logic serData, strobe, psActive, zcN, serRise, oscRise, preRise;

  // First stage feeds only the second stage
  always_comb begin
    syncA_next = {prescTickIn, oscTickIn, pumpTristateNIn, powerSaveNIn,
                  latchStrobeIn, serClkIn, serDataIn};
    syncB_next = syncA_reg;
    prev_next  = {syncB_reg[pss_pkg::SY_PRE], syncB_reg[pss_pkg::SY_OSC],
                  syncB_reg[pss_pkg::SY_SCLK]};
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      prev_reg  <= '0;
    end else begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
      prev_reg  <= prev_next;
    end
  end

  // Edge detection on the clean copies
  assign serData  = syncB_reg[pss_pkg::SY_DATA];
  assign strobe   = syncB_reg[pss_pkg::SY_LE];
  assign psActive = !syncB_reg[pss_pkg::SY_PSN];
  assign zcN      = syncB_reg[pss_pkg::SY_ZCN];
  assign serRise  = syncB_reg[pss_pkg::SY_SCLK] && !prev_reg[0];
  assign oscRise  = syncB_reg[pss_pkg::SY_OSC] && !prev_reg[1];
  assign preRise  = syncB_reg[pss_pkg::SY_PRE] && !prev_reg[2];

  // ----------------------------------------------------------------
  // Shift register and latches
  // ----------------------------------------------------------------
  logic [pss_pkg::SHIFT_W-1:0] shift_reg, shift_next;
  logic [pss_pkg::REFL_W-1:0]  refLatch_reg, refLatch_next;
  logic [pss_pkg::DIVL_W-1:0]  divLatch_reg, divLatch_next;
  logic                        monSel_reg, monSel_next;

  // Not gated by power save, so host may reload while asleep
  always_comb begin
    shift_next    = shift_reg;
    refLatch_next = refLatch_reg;
    divLatch_next = divLatch_reg;
    monSel_next   = monSel_reg;
    // [R19] [R16] shift on edge
    if (serRise) begin
      shift_next = {shift_reg[pss_pkg::SHIFT_W-2:0], serData};
    end
    // [R21] [R20] [R22] strobe to latch
    if (strobe) begin
      if (shift_reg[pss_pkg::TGT_POS]) begin
        refLatch_next = shift_reg[pss_pkg::REFL_W-1:0];
      end else begin
        divLatch_next = shift_reg[pss_pkg::DIV_FIELD_LSB +: pss_pkg::DIVL_W];
        monSel_next   = shift_reg[pss_pkg::DIV_LDS_POS];
      end
    end
  end

  // [R23] only a strobe changes latches
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg    <= '0;
      refLatch_reg <= pss_pkg::REFL_RST;
      divLatch_reg <= pss_pkg::DIVL_RST;
      monSel_reg   <= pss_pkg::MON_RST;
    end else begin
      shift_reg    <= shift_next;
      refLatch_reg <= refLatch_next;
      divLatch_reg <= divLatch_next;
      monSel_reg   <= monSel_next;
    end
  end

  // Field decode, plain binary with the highest bit first
  logic [pss_pkg::REF_W-1:0]  refRatio;
  logic [pss_pkg::MAIN_W-1:0] mainRatio;
  logic [pss_pkg::SWAL_W-1:0] swallowVal;
  logic                       polarity;
  // [R1] [R2] [R4] [R5] field widths
  assign refRatio   = refLatch_reg[pss_pkg::REF_R_LSB +: pss_pkg::REF_W];
  assign mainRatio  = divLatch_reg[pss_pkg::DIVL_N_LSB +: pss_pkg::MAIN_W];
  assign swallowVal = divLatch_reg[pss_pkg::DIVL_A_LSB +: pss_pkg::SWAL_W];
  assign polarity   = refLatch_reg[pss_pkg::REF_FC_POS];

  // ----------------------------------------------------------------
  // Dividers and swallow counter
  // ----------------------------------------------------------------
  logic refPulse, fbPulse;
  logic [pss_pkg::SWAL_W-1:0] swal_reg, swal_next;

  // [R12] dividers stop in power save
  pss_divider #(.W(pss_pkg::REF_W)) u_refDiv (
    .clk(sys_clk), .resetn(resetn), .run(!psActive), .tick(oscRise),
    .ratio(refRatio), .pulse(refPulse)
  );
  pss_divider #(.W(pss_pkg::MAIN_W)) u_mainDiv (
    .clk(sys_clk), .resetn(resetn), .run(!psActive), .tick(preRise),
    .ratio(mainRatio), .pulse(fbPulse)
  );

  // Swallow count reloads at every feedback cycle
  always_comb begin
    swal_next = swal_reg;
    if (psActive) begin
      swal_next = '0;
    end else if (fbPulse) begin
      swal_next = swallowVal;
    end else if (preRise && swal_reg != '0) begin
      swal_next = swal_reg - pss_pkg::SWAL_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      swal_reg <= '0;
    end else begin
      swal_reg <= swal_next;
    end
  end

  // ----------------------------------------------------------------
  // Wake window and phase detector
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg, ctrl_next;
  logic [pss_pkg::WAKE_W-1:0] wake_reg, wake_next;
  logic [pss_pkg::CAP_W-1:0]  errW_reg, errW_next;
  logic up_reg, up_next, dn_reg, dn_next, wakeActive, allowDrive;

  assign wakeActive = (wake_reg != '0) && !psActive;
  // [R15] cap error width after wake
  assign allowDrive = !wakeActive || (errW_reg < ctrl_reg[pss_pkg::CTRL_CAP_LSB +: pss_pkg::CAP_W]);

  // Up means reference leads; both set cancels out
  always_comb begin
    wake_next = wake_reg;
    up_next   = up_reg | refPulse;
    dn_next   = dn_reg | fbPulse;
    errW_next = '0;
    if (up_next && dn_next) begin
      up_next = 1'b0;
      dn_next = 1'b0;
    end
    if (psActive) begin
      wake_next = ctrl_reg[pss_pkg::CTRL_WAKE_LSB +: pss_pkg::WAKE_W];
      up_next   = 1'b0;
      dn_next   = 1'b0;
    end else if (wake_reg != '0) begin
      wake_next = wake_reg - pss_pkg::WAKE_W'(1);
    end
    if ((up_reg || dn_reg) && errW_reg != '1) begin
      errW_next = errW_reg + pss_pkg::CAP_W'(1);
    end else if (up_reg || dn_reg) begin
      errW_next = errW_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake_reg <= '0;
      up_reg   <= 1'b0;
      dn_reg   <= 1'b0;
      errW_reg <= '0;
    end else begin
      wake_reg <= wake_next;
      up_reg   <= up_next;
      dn_reg   <= dn_next;
      errW_reg <= errW_next;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  logic effUp, effDn, lockDet_reg, lockDet_next;
  logic pumpOut_next, pumpOeN_next, phaseRef_next, phaseFbOeN_next;
  logic monOut_next, presc_next, modHigh_next;

  // [R8] polarity swaps the error sense
  assign effUp = polarity ? up_reg : dn_reg;
  assign effDn = polarity ? dn_reg : up_reg;

  always_comb begin
    // [R9] [R10] comparator table
    pumpOut_next    = effUp;
    pumpOeN_next    = !((effUp || effDn) && allowDrive && zcN && !psActive);
    phaseRef_next   = effDn && !psActive;
    phaseFbOeN_next = !(effUp && !psActive);
    // [R14] locked shown in power save
    lockDet_next    = psActive || !(up_reg || dn_reg);
    // [R7] [R11] shared output select
    if (monSel_reg) begin
      monOut_next = polarity ? refPulse : fbPulse;
    end else begin
      monOut_next = lockDet_next;
    end
    // [R6] prescaler ratio and modulus
    presc_next   = refLatch_reg[pss_pkg::REF_SW_POS];
    modHigh_next = (swal_next != '0);
  end

  // [R13] tristate pin forces high impedance via pumpOeN_next
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pumpOut          <= 1'b0;
      pumpOeN          <= 1'b1;
      phaseRefOut      <= 1'b0;
      phaseFbOeN       <= 1'b1;
      lockDet_reg      <= 1'b1;
      lockMonitorOut   <= 1'b1;
      prescRatioSel    <= 1'b1;
      prescModulusHigh <= 1'b0;
      powerSaveActive  <= 1'b1;
    end else begin
      pumpOut          <= pumpOut_next;
      pumpOeN          <= pumpOeN_next;
      phaseRefOut      <= phaseRef_next;
      phaseFbOeN       <= phaseFbOeN_next;
      lockDet_reg      <= lockDet_next;
      lockMonitorOut   <= monOut_next;
      prescRatioSel    <= presc_next;
      prescModulusHigh <= modHigh_next;
      powerSaveActive  <= psActive;
    end
  end

  // Open drain only ever pulls low
  assign phaseFbOut = 1'b0;

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  logic [31:0] rdata_next;
  logic        hit, wrOk;

  assign hit     = paddr == pss_pkg::ADDR_CTRL || paddr == pss_pkg::ADDR_REF ||
                   paddr == pss_pkg::ADDR_DIV  || paddr == pss_pkg::ADDR_STAT;
  assign wrOk    = paddr == pss_pkg::ADDR_CTRL;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!hit || (pwrite && !wrOk));

  // Read data captured in setup so it is a flop in access
  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = prdata;
    if (psel && penable && pwrite && wrOk) begin
      ctrl_next = pwdata;
    end
    if (psel && !penable) begin
      case (paddr)
        pss_pkg::ADDR_CTRL: rdata_next = ctrl_reg;
        pss_pkg::ADDR_REF:  rdata_next = {15'h0000, refLatch_reg};
        pss_pkg::ADDR_DIV:  rdata_next = {13'h0000, monSel_reg, divLatch_reg};
        pss_pkg::ADDR_STAT: begin
          rdata_next = 32'h0000_0000;
          rdata_next[pss_pkg::STAT_LOCK] = lockDet_reg;
          rdata_next[pss_pkg::STAT_UP]   = up_reg;
          rdata_next[pss_pkg::STAT_DN]   = dn_reg;
          rdata_next[pss_pkg::STAT_PS]   = psActive;
          rdata_next[pss_pkg::STAT_WAKE] = wakeActive;
          rdata_next[pss_pkg::STAT_MON]  = monSel_reg;
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= pss_pkg::CTRL_RST;
      prdata   <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata   <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_sleepEnd;
    psActive ##1 !psActive;
  endsequence

  property p_shift;
    serRise |=> shift_reg[0] == $past(serData);
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit not shifted"); // [R19]

  property p_refLoad;
    strobe && shift_reg[0] |=> refLatch_reg == $past(shift_reg[16:0]);
  endproperty
  a_refLoad: assert property (p_refLoad) else $error("reference latch not loaded"); // [R20]

  property p_divLoad;
    strobe && !shift_reg[0] |=> divLatch_reg == $past(shift_reg[18:1]);
  endproperty
  a_divLoad: assert property (p_divLoad) else $error("divider latch not loaded"); // [R21]

  property p_hold;
    !strobe |=> $stable(refLatch_reg) && $stable(divLatch_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without strobe"); // [R23]

  property p_sleepOut;
    psActive |=> pumpOeN && lockDet_reg;
  endproperty
  a_sleepOut: assert property (p_sleepOut) else $error("pump or lock wrong in power save"); // [R14]

  property p_tri;
    !zcN |=> pumpOeN;
  endproperty
  a_tri: assert property (p_tri) else $error("pump driven while tristated"); // [R13]

  property p_polHigh;
    polarity && up_reg && !dn_reg && !psActive |=> !phaseRefOut && !phaseFbOeN;
  endproperty
  a_polHigh: assert property (p_polHigh) else $error("polarity high table broken"); // [R9]

  property p_polLow;
    !polarity && up_reg && !dn_reg && !psActive |=> phaseRefOut && phaseFbOeN;
  endproperty
  a_polLow: assert property (p_polLow) else $error("polarity low table broken"); // [R10]

  property p_monitor;
    monSel_reg && polarity |=> lockMonitorOut == $past(refPulse);
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor not reference clock"); // [R11]

  property p_divStop;
    psActive [*2] |-> !refPulse && !fbPulse;
  endproperty
  a_divStop: assert property (p_divStop) else $error("dividers run in power save"); // [R12]

  property p_wake;
    s_sleepEnd |-> wake_reg == ctrl_reg[15:0] ##1 (wakeActive && errW_reg >= ctrl_reg[23:16]) |-> pumpOeN;
  endproperty
  a_wake: assert property (p_wake) else $error("wake error not limited"); // [R15]

  // [R15] pump floats once error outlasts cap
  property p_cap;
    wakeActive && errW_reg >= ctrl_reg[pss_pkg::CTRL_CAP_LSB +: pss_pkg::CAP_W] |=> pumpOeN;
  endproperty
  a_cap: assert property (p_cap) else $error("error drive exceeds wake cap"); // [R15]
endmodule : pss_ctl

/* File: design/pss_pkg.sv */
// ----------------------------------------------------------------
// Field widths and latch layout
// ----------------------------------------------------------------
package pss_pkg;
  localparam int REF_W   = 14;  // Reference divide ratio width
  localparam int MAIN_W  = 11;  // Main counter width
  localparam int SWAL_W  = 7;   // Swallow counter width
  localparam int SHIFT_W = 20;  // Serial shift register width
  localparam int REFL_W  = 17;  // Reference latch width
  localparam int DIVL_W  = 18;  // Divider latch width

  // Serial word: first bit in ends at the top, target select last
  localparam int TGT_POS       = 0;
  localparam int REF_R_LSB     = 1;   // Ratio in [14:1] of the word
  localparam int REF_FC_POS    = 15;  // Phase polarity select
  localparam int REF_SW_POS    = 16;  // Prescaler ratio select
  localparam int DIV_FIELD_LSB = 1;   // Swallow+main start in the word
  localparam int DIV_LDS_POS   = 19;  // Monitor select
  localparam int DIVL_A_LSB    = 0;   // Swallow inside divider latch
  localparam int DIVL_N_LSB    = 7;   // Main ratio inside divider latch

  // Synchroniser bit indices
  localparam int SY_DATA = 0;
  localparam int SY_SCLK = 1;
  localparam int SY_LE   = 2;
  localparam int SY_PSN  = 3;
  localparam int SY_ZCN  = 4;
  localparam int SY_OSC  = 5;
  localparam int SY_PRE  = 6;
  localparam int SY_W    = 7;

  // ----------------------------------------------------------------
  // APB map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_REF  = 8'h04;
  localparam logic [7:0] ADDR_DIV  = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam int CTRL_WAKE_LSB = 0;
  localparam int WAKE_W        = 16;
  localparam int CTRL_CAP_LSB  = 16;
  localparam int CAP_W         = 8;
  localparam int STAT_LOCK     = 0;
  localparam int STAT_UP       = 1;
  localparam int STAT_DN       = 2;
  localparam int STAT_PS       = 3;
  localparam int STAT_WAKE     = 4;
  localparam int STAT_MON      = 5;

  // Reset values
  localparam logic [REFL_W-1:0] REFL_RST = 17'h1800B;     // R=5, both bits high
  localparam logic [DIVL_W-1:0] DIVL_RST = 18'h00280;     // N=5, A=0
  localparam logic              MON_RST  = 1'h0;
  localparam logic [31:0]       CTRL_RST = 32'h0004_0064; // Cap 4, wake 100
endpackage : pss_pkg

/* File: design/pss_divider.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Programmable divider, one pulse per ratio ticks
// ----------------------------------------------------------------
module pss_divider #(
  parameter int W = 14
) (
  input  wire logic         clk,     // System clock
  input  wire logic         resetn,  // Async reset, low
  input  wire logic         run,     // Low holds count at zero
  input  wire logic         tick,    // One-cycle input event
  input  wire logic [W-1:0] ratio,   // Divide ratio
  output logic              pulse    // One-cycle output event
);
  logic [W-1:0] count_reg, count_next;
  logic         pulse_next;

  // Ratio read live, so a new load takes effect in the count in progress
  always_comb begin
    count_next = count_reg;
    pulse_next = 1'b0;
    if (!run) begin
      count_next = '0;
    end else if (tick) begin
      if (count_reg >= ratio - W'(1)) begin
        count_next = '0;
        pulse_next = 1'b1;
      end else begin
        count_next = count_reg + W'(1);
      end
    end
  end

  // Count registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
      pulse     <= 1'b0;
    end else begin
      count_reg <= count_next;
      pulse     <= pulse_next;
    end
  end
endmodule : pss_divider

/* File: tb/pss_host_model.sv */
`timescale 1ns/100ps
// Host end of the three-wire link; link clock stands low between words
module pss_host_model (
  output logic serData,     // Serial data
  output logic serClk,      // Serial clock
  output logic latchStrobe  // Latch strobe
);
  // Idle levels at power-on
  initial begin
    serData     = 1'b0;
    serClk      = 1'b0;
    latchStrobe = 1'b0;
  end

  task automatic send(input logic [19:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serData = w[i];
      #40 serClk = 1'b1;  // Data set up well before the edge
      #80 serClk = 1'b0;
      #40;
    end
    serData = ~w[0];  // Released line never shows the stale bit
    #100 latchStrobe = 1'b1;
    #200 latchStrobe = 1'b0;
    #100;
  endtask : send
endmodule : pss_host_model

/* File: tb/test_pss_ctl.sv */
`timescale 1ns/100ps
// Bench for the synthesizer control block
module test_pss_ctl;
  typedef struct {
    logic [13:0] r;
    logic [10:0] n;
    logic [6:0]  a;
    logic        sw, fc, monitor_select;
    logic [16:0] expRef;
    logic [18:0] expDiv;
  } pss_row_t;
  logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        serDataIn, serClkIn, latchStrobeIn, powerSaveNIn, pumpTristateNIn;
  logic        oscTickIn, prescTickIn, prescRatioSel, prescModulusHigh, pumpOut;
  logic        pumpOeN, phaseRefOut, phaseFbOut, phaseFbOeN, lockMonitorOut, powerSaveActive;
  int          failures = 0, totalChecks = 0, cycles = 0, mon, drv, hi;
  // Ratios kept at five or more
  pss_row_t    rows[4] = '{
    '{14'h5, 11'h5, 7'h0, 1'h1, 1'h1, 1'h0, 17'h1800B, 19'h00280},
    '{14'h3FFF, 11'h7FF, 7'h7F, 1'h0, 1'h0, 1'h1, 17'h07FFF, 19'h7FFFF},
    '{14'h6, 11'h6, 7'h1, 1'h0, 1'h1, 1'h0, 17'h0800D, 19'h00301},
    '{14'h2AAA, 11'h555, 7'h2A, 1'h1, 1'h0, 1'h1, 17'h15555, 19'h6AAAA}
  };

  pss_ctl u_dut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serDataIn, .serClkIn, .latchStrobeIn, .powerSaveNIn, .pumpTristateNIn, .oscTickIn,
    .prescTickIn, .prescRatioSel, .prescModulusHigh, .pumpOut, .pumpOeN, .phaseRefOut, .phaseFbOut,
    .phaseFbOeN, .lockMonitorOut, .powerSaveActive);
  pss_host_model u_host (.serData(serDataIn), .serClk(serClkIn), .latchStrobe(latchStrobeIn));

  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end

  // Verdict and end of run
  task automatic results();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check

  // One APB transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin  // Only the bench timeout ends a hang
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);  // Idle cycle keeps strobes from being set twice
  endtask : apb

  task automatic load(input pss_row_t t);
    u_host.send({3'h0, t.sw, t.fc, t.r, 1'h1}, 17);
    u_host.send({t.monitor_select, t.n, t.a, 1'h0}, 20);
    @(posedge sys_clk);
  endtask : load

  // Oscillator or prescaler ticks; counts monitor pulses and pump drive
  task automatic ticks(input logic fb, input int n);
    mon = 0;
    drv = 0;
    hi  = 0;
    for (int i = 0; i < 4 * n + 8; i++) begin
      oscTickIn   <= !fb && i < 4 * n && i % 4 < 2;
      prescTickIn <= fb && i < 4 * n && i % 4 < 2;
      @(posedge sys_clk);
      mon += (lockMonitorOut === 1'h1);
      drv += (pumpOeN === 1'h0);
      hi  += (prescModulusHigh === 1'h1);
    end
  endtask : ticks

  // Main sequence
  initial begin
    resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    powerSaveNIn = 1'h0;
    pumpTristateNIn = 1'h1;
    oscTickIn = 1'h0;
    prescTickIn = 1'h0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'h1;
    repeat (3) @(posedge sys_clk);
    apb(1'h0, pss_pkg::ADDR_CTRL, 32'h0);
    check(rd, pss_pkg::CTRL_RST, "ctrl reset");
    apb(1'h0, pss_pkg::ADDR_REF, 32'h0);
    check(rd, 32'(pss_pkg::REFL_RST), "ref reset");
    apb(1'h0, pss_pkg::ADDR_DIV, 32'h0);
    check(rd, 32'(pss_pkg::DIVL_RST), "div reset");
    check(32'(powerSaveActive), 32'h1, "saving at power-on");
    repeat (100) @(posedge sys_clk);
    powerSaveNIn <= 1'h1;
    apb(1'h0, 8'h10, 32'h0);
    check(32'(err), 32'h1, "unmapped err");
    check(rd, 32'h0, "unmapped data");
    apb(1'h1, pss_pkg::ADDR_REF, 32'hFFFFFFFF);
    check(32'(err), 32'h1, "ro write err");
    apb(1'h1, pss_pkg::ADDR_CTRL, 32'h00030050);
    apb(1'h0, pss_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h00030050, "ctrl write");
    $display("reset and map test done");
    foreach (rows[i]) begin
      load(rows[i]);
      apb(1'h0, pss_pkg::ADDR_REF, 32'h0);
      check(rd, 32'(rows[i].expRef), "ref latch");
      apb(1'h0, pss_pkg::ADDR_DIV, 32'h0);
      check(rd, 32'(rows[i].expDiv), "div latch");
      check(32'(prescRatioSel), 32'(rows[i].sw), "prescaler sel");
      apb(1'h0, pss_pkg::ADDR_STAT, 32'h0);
      check(32'(rd[5]), 32'(rows[i].monitor_select), "monitor sel");
      $display("row %0d done", i);
    end
    load('{14'h5, 11'h5, 7'h0, 1'h1, 1'h1, 1'h1, 17'h0, 19'h0});
    ticks(1'h0, 10);
    check(32'(mon), 32'h2, "ref monitor pulses");
    check(32'({pumpOut, pumpOeN, phaseRefOut, phaseFbOeN, phaseFbOut}), 32'h10, "ref leads");
    $display("polarity high test done");
    resetn <= 1'h0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'h1;
    repeat (3) @(posedge sys_clk);
    load('{14'h5, 11'h5, 7'h0, 1'h1, 1'h0, 1'h1, 17'h0, 19'h0});
    ticks(1'h1, 5);
    check(32'(mon), 32'h1, "fb monitor pulses");
    check(32'({pumpOut, pumpOeN, phaseRefOut, phaseFbOeN}), 32'h8, "fb leads");
    pumpTristateNIn <= 1'h0;
    repeat (4) @(posedge sys_clk);
    check(32'(pumpOeN), 32'h1, "tristate floats");
    pumpTristateNIn <= 1'h1;
    repeat (4) @(posedge sys_clk);
    check(32'(pumpOeN), 32'h0, "tristate released");
    // Two reference pulses: the first cancels the pending down, the second leads
    ticks(1'h0, 10);
    check(32'(mon), 32'h0, "fb monitor ignores ref");
    check(32'({pumpOut, pumpOeN, phaseRefOut, phaseFbOeN}), 32'h3, "ref leads low");
    $display("polarity low test done");
    powerSaveNIn <= 1'h0;
    repeat (4) @(posedge sys_clk);
    check(32'({powerSaveActive, pumpOeN}), 32'h3, "saving floats pump");
    load('{14'h7, 11'h9, 7'h3, 1'h0, 1'h0, 1'h0, 17'h0, 19'h0});
    check(32'(lockMonitorOut), 32'h1, "saving shows lock");
    apb(1'h0, pss_pkg::ADDR_DIV, 32'h0);
    check(rd, 32'h00483, "load while saving");
    powerSaveNIn <= 1'h1;
    ticks(1'h1, 12);
    // Mid-run reset restored the control word, so the cap is the reset one
    check(32'(drv), 32'(pss_pkg::CTRL_RST[pss_pkg::CTRL_CAP_LSB +: pss_pkg::CAP_W]), "wake drive capped");
    // Swallow 3: three prescaler periods of 4 cycles, less the reload cycle
    check(32'(hi), 32'hB, "swallow phase length");
    apb(1'h0, pss_pkg::ADDR_REF, 32'h0);
    check(rd, 32'h0000F, "ref held");
    $display("power save test done");
    results();
  end
endmodule : test_pss_ctl
